// File: combo_seq_pkg.sv
/*
  Shared constants and carriers of the protection sequencer.
  Assumes a 250 MHz system clock and comparator results that are
  already synchronous to it.
*/
package combo_seq_pkg;

  // ****************************************************************
  // Clock and delays
  // ****************************************************************
  localparam int CLK_MHZ          = 250;
  localparam int CLK_PERIOD_NS    = 1000 / CLK_MHZ;
  localparam int START_DELAY_NS   = 20_000_000;
  localparam int STOP_DELAY_NS    = 5_000_000;
  localparam int REDUNDANT_OVERVOLTAGE_FILTER_NS   = 20_000;
  localparam int BO_OK_DELAY_NS   = 1_000;
  localparam int BO_FAIL_DELAY_NS = 1_000;
  localparam int ABNORMAL_NS      = 1_000;
  localparam int START_CYC  = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_CYC   = (STOP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REDUNDANT_OVERVOLTAGE_CYC   = (REDUNDANT_OVERVOLTAGE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BO_OK_CYC  = (BO_OK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BO_BAD_CYC = (BO_FAIL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ABN_CYC    = (ABNORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Comparator thresholds, applied outside the logic
  localparam int FB_UV_OFF_PCT  = 8;
  localparam int FB_UV_ON_PCT   = 12;
  localparam int REDUNDANT_OVERVOLTAGE_PCT       = 107;
  localparam int BULK_GOOD_PCT  = 95;
  localparam int FF_SOFT_MV     = 1000;
  localparam int FF_LATCH_MV    = 1500;
  localparam int SS_RESET_MV    = 150;
  localparam int REMOTE_OFF_MV  = 3000;
  localparam int REMOTE_ON_MV   = 1000;

  // ****************************************************************
  // Timer slots
  // ****************************************************************
  localparam int TMR_REDUNDANT_OVERVOLTAGE  = 0;
  localparam int TMR_ABN   = 1;
  localparam int TMR_BOK   = 2;
  localparam int TMR_BOF   = 3;
  localparam int TMR_START = 4;
  localparam int TMR_STOP  = 5;
  localparam int TMR_N     = 6;
  localparam int TMR_W     = 32;

  // ****************************************************************
  // Register map and oscillator
  // ****************************************************************
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_RAMP   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam int          RAMP_W      = 16;
  localparam logic [15:0] RAMP_TOP_RST = 16'h0100;
  localparam logic [15:0] DIS_STEP    = 16'h0004;
  localparam logic        SKIP_EN_RST = 1'b0;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_RUN, SEQ_STOP}
    seq_t;

  // Comparator results, one bit each
  typedef struct packed {
    logic fb_below_uv;
    logic fb_above_uv_on;
    logic redundant_overvoltage;
    logic ctrl_at_max;
    logic ctrl_below_min;
    logic bulk_above_good;
    logic pg_above;
    logic bo_above;
    logic line_brownout;
    logic ff_soft;
    logic ff_latch;
    logic ss_below_reset;
    logic skip_high;
    logic hs_supply_ok;
    logic remote_above_off;
    logic remote_below_on;
    logic supply_ok;
    logic thermal_shutdown;
  } comp_t;

  // Status word, low bits of the status register
  typedef struct packed {
    logic remote_on;
    logic undervoltage;
    logic latched;
    logic abnormal_off;
    logic bo_ok;
    logic front_end_good;
    logic ss_discharge;
    seq_t seq;
  } stat_t;

endpackage

// File: delay_timer.sv
/*
  Saturating tick counter used for every filter and delay.
  Assumes the limit is steady while the timer runs.
*/
`timescale 1ns/1ps
`default_nettype none

module delay_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Control
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_limit,
  // Result
  output logic              o_done
);

  typedef struct packed {
    logic [W-1:0] count;
  } tmr_t;

  tmr_t r_reg;
  tmr_t r_next;

  // Dropping the run level restarts the count from zero
  always_comb begin
    r_next = r_reg;
    if (!i_run) begin
      r_next.count = '0;
    end else if (r_reg.count != i_limit) begin
      r_next.count = r_reg.count + W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_done = i_run && (r_reg.count == i_limit);

endmodule

`default_nettype wire

// File: combo_protection_sequencer.sv
/*
  Protection and sequencing logic of a boost front end and resonant
  half-bridge stage, with a Wishbone classic register slave.
  Assumes all comparator results are synchronous to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Feedback below 8% stops the device; above 12% it resumes.
// - Filtered redundant over-voltage latches off both stages.
// - Redundant over-voltage must persist 20 us before latching.
// - Redundant comparator trips at 107% of reference, apart from OVP.
// - After that, resonant stops at once, without the stop delay; both stay latched.
// - Oscillator toggles a phase flop; drives alternate at half rate.
// - Both drives are held off for the whole discharge interval.
// - Discharge starts at ramp top and ends when ramp reaches zero.
// - Ramp forced to zero while resonant enable is low; it keeps running during the stop delay.
// - Power good asserts low after front end good plus 20 ms.
// - Power good released when bulk drops to power good level.
// - Stop delay expiry halts the resonant drives.
// - Brown-out qualified by separate rising and falling delays.
// - Fast fault above 1 V discharges soft start until 150 mV.
// - Fast fault above 1.5 V latches off both stages.
// - Listed fault events trigger soft start discharge, except over-voltage and the 1.5 V latch.
// - Discharge holds until soft start level is below 150 mV.
// - Resonant start waits until soft start discharge has ended.
// - With skip enabled, low skip input suppresses drive pulses.
// - High-side drive inhibited while floating supply is low.
// - Latch clears only on supply, remote or line brown-out recycle.
// - Remote above 3 V stops both at once; below 1 V starts.
module combo_protection_sequencer #(
  parameter int unsigned START_CYCLES = combo_seq_pkg::START_CYC,
  parameter int unsigned STOP_CYCLES  = combo_seq_pkg::STOP_CYC,
  parameter int unsigned REDUNDANT_OVERVOLTAGE_CYCLES  = combo_seq_pkg::REDUNDANT_OVERVOLTAGE_CYC,
  parameter int unsigned BO_OK_CYCLES = combo_seq_pkg::BO_OK_CYC,
  parameter int unsigned BO_BAD_CYCLES = combo_seq_pkg::BO_BAD_CYC,
  parameter int unsigned ABN_CYCLES   = combo_seq_pkg::ABN_CYC
) (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // Comparator results
  input  wire combo_seq_pkg::comp_t i_comp,
  // Wishbone classic slave
  input  wire logic                i_wb_cyc,
  input  wire logic                i_wb_stb,
  input  wire logic                i_wb_we,
  input  wire logic [7:0]          i_wb_adr,
  input  wire logic [3:0]          i_wb_sel,
  input  wire logic [31:0]         i_wb_dat,
  output logic                     o_wb_ack,
  output logic [31:0]              o_wb_dat,
  // Stage control
  output logic                     o_front_end_enable,
  output logic                     o_front_end_good,
  output logic                     o_resonant_enable,
  output logic                     o_power_good_low,
  output logic                     o_soft_start_discharge,
  output logic                     o_latched_off,
  // Half-bridge drives
  output logic                     o_low_side_drive,
  output logic                     o_high_side_drive
);

  localparam int RW = combo_seq_pkg::RAMP_W;
  localparam int TW = combo_seq_pkg::TMR_W;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    combo_seq_pkg::seq_t seq;
    logic          latched;
    logic          abn_off;
    logic          uv;
    logic          remote_on;
    logic          bo_ok;
    logic          fe_run;
    logic          fe_good;
    logic          pg_low;
    logic          ss_dis;
    logic          res_en;
    logic [RW-1:0] ramp;
    logic          discharging;
    logic          phase;
    logic          low;
    logic          high;
    logic          skip_en;
    logic [RW-1:0] ramp_top;
    logic          ack;
    logic [31:0]   dat;
  } top_t;

  top_t r_reg;
  top_t r_next;

  combo_seq_pkg::comp_t c;
  assign c = i_comp;

  // ****************************************************************
  // Delay timers
  // ****************************************************************
  localparam logic [TW-1:0] LIMITS [combo_seq_pkg::TMR_N] = '{
    TW'(REDUNDANT_OVERVOLTAGE_CYCLES), TW'(ABN_CYCLES), TW'(BO_OK_CYCLES),
    TW'(BO_BAD_CYCLES), TW'(START_CYCLES), TW'(STOP_CYCLES)
  };

  logic [combo_seq_pkg::TMR_N-1:0] t_run;
  logic [combo_seq_pkg::TMR_N-1:0] t_done;

  // Comparator at 107%, separate from the regular limit, so
  // the filter sees only this bit
  assign t_run[combo_seq_pkg::TMR_REDUNDANT_OVERVOLTAGE] = c.redundant_overvoltage;
  // Persistence counts only while the front end is actually running
  assign t_run[combo_seq_pkg::TMR_ABN] = r_reg.fe_run &&
    (c.ctrl_at_max || c.ctrl_below_min);
  assign t_run[combo_seq_pkg::TMR_BOK] = c.bo_above && !r_reg.bo_ok;
  assign t_run[combo_seq_pkg::TMR_BOF] = !c.bo_above && r_reg.bo_ok;
  assign t_run[combo_seq_pkg::TMR_START] =
    (r_reg.seq == combo_seq_pkg::SEQ_START);
  assign t_run[combo_seq_pkg::TMR_STOP] =
    (r_reg.seq == combo_seq_pkg::SEQ_STOP);

  genvar gi;
  generate
    for (gi = 0; gi < combo_seq_pkg::TMR_N; gi++) begin : g_tmr
      delay_timer #(
        .W       (TW)
      ) u_tmr (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_run   (t_run[gi]),
        .i_limit (LIMITS[gi]),
        .o_done  (t_done[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Register access helpers
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [31:0] read_word(input top_t s,
                                            input logic [7:0] adr);
    combo_seq_pkg::stat_t st;
    st = '{s.remote_on, s.uv, s.latched, s.abn_off, s.bo_ok,
           s.fe_good, s.ss_dis, s.seq};
    case (adr)
      combo_seq_pkg::ADDR_CTRL:   read_word = 32'(s.skip_en);
      combo_seq_pkg::ADDR_RAMP:   read_word = 32'(s.ramp_top);
      combo_seq_pkg::ADDR_STATUS: read_word = 32'(st);
      default:                    read_word = 32'h0000_0000;
    endcase
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic stop_exp;
  logic res_kill;
  logic recycle;
  logic latch_set;
  logic ss_trig;
  logic pulse_ok;
  logic wr;
  logic [31:0] wword;

  always_comb begin
    r_next    = r_reg;
    stop_exp  = 1'b0;
    res_kill  = 1'b0;
    recycle   = 1'b0;
    latch_set = 1'b0;
    ss_trig   = 1'b0;
    pulse_ok  = 1'b0;
    wr        = 1'b0;
    wword     = 32'h0000_0000;

    // Remote hysteresis: above the off level wins
    if (c.remote_above_off) begin
      r_next.remote_on = 1'b0;
    end else if (c.remote_below_on) begin
      r_next.remote_on = 1'b1;
    end

    // Open-loop protection with hysteresis
    r_next.uv = c.fb_below_uv || (r_reg.uv && !c.fb_above_uv_on);

    if (t_done[combo_seq_pkg::TMR_BOK]) begin
      r_next.bo_ok = 1'b1;
    end else if (t_done[combo_seq_pkg::TMR_BOF]) begin
      r_next.bo_ok = 1'b0;
    end

    // Latched state lags one cycle in the kill terms on purpose,
    // so the sequence logic never loops through the latch
    res_kill = !c.supply_ok || c.thermal_shutdown ||
               !r_next.remote_on || r_reg.latched ||
               !r_reg.bo_ok;

    r_next.fe_run = c.supply_ok && !c.thermal_shutdown &&
                    r_next.remote_on && !c.line_brownout &&
                    !r_next.uv && !r_reg.latched &&
                    !r_reg.abn_off;
    // Good drops with any front-end fault
    r_next.fe_good = r_next.fe_run &&
                     (r_reg.fe_good || c.bulk_above_good);

    case (r_reg.seq)
      combo_seq_pkg::SEQ_IDLE: begin
        if (r_next.fe_good && !res_kill) begin
          r_next.seq = combo_seq_pkg::SEQ_START;
        end
      end
      combo_seq_pkg::SEQ_START: begin
        if (!r_next.fe_good || res_kill) begin
          r_next.seq = combo_seq_pkg::SEQ_IDLE;
        end else if (t_done[combo_seq_pkg::TMR_START] && !r_reg.ss_dis) begin
          // Waits for a finished discharge so each start is fresh
          r_next.seq    = combo_seq_pkg::SEQ_RUN;
          r_next.pg_low = 1'b1;
        end
      end
      combo_seq_pkg::SEQ_RUN: begin
        if (res_kill) begin
          r_next.seq    = combo_seq_pkg::SEQ_IDLE;
          r_next.pg_low = 1'b0;
        end else if (!r_next.fe_good || !c.pg_above) begin
          r_next.seq    = combo_seq_pkg::SEQ_STOP;
          r_next.pg_low = 1'b0;
        end
      end
      combo_seq_pkg::SEQ_STOP: begin
        if (res_kill) begin
          r_next.seq = combo_seq_pkg::SEQ_IDLE;
        end else if (t_done[combo_seq_pkg::TMR_STOP]) begin
          r_next.seq = combo_seq_pkg::SEQ_IDLE;
          stop_exp   = 1'b1;
        end
      end
      default: begin
        r_next.seq    = combo_seq_pkg::SEQ_IDLE;
        r_next.pg_low = 1'b0;
      end
    endcase

    // Latch handling; a set in the same cycle as a recycle wins
    recycle   = !c.supply_ok || !r_next.remote_on ||
                c.line_brownout;
    latch_set = t_done[combo_seq_pkg::TMR_REDUNDANT_OVERVOLTAGE] ||
                c.ff_latch ||
                (r_reg.abn_off && stop_exp);
    r_next.latched = latch_set || (r_reg.latched && !recycle);
    r_next.abn_off = t_done[combo_seq_pkg::TMR_ABN] ||
                     (r_reg.abn_off && !recycle);

    // Soft start discharge
    ss_trig = !r_reg.bo_ok || stop_exp || c.ff_soft ||
              !c.supply_ok || r_next.uv || !r_next.remote_on ||
              c.thermal_shutdown;
    r_next.ss_dis = ss_trig ||
                    (r_reg.ss_dis && !c.ss_below_reset);

    r_next.res_en = (r_next.seq == combo_seq_pkg::SEQ_RUN) ||
                    (r_next.seq == combo_seq_pkg::SEQ_STOP);

    // Oscillator: ramp up one step a tick, discharge by DIS_STEP
    if (!r_next.res_en) begin
      r_next.ramp        = '0;
      r_next.discharging = 1'b0;
      r_next.phase       = 1'b0;
    end else if (r_reg.discharging) begin
      if (r_reg.ramp <= combo_seq_pkg::DIS_STEP) begin
        r_next.ramp        = '0;
        r_next.discharging = 1'b0;
      end else begin
        r_next.ramp = r_reg.ramp - combo_seq_pkg::DIS_STEP;
      end
    end else if (r_reg.ramp >= r_reg.ramp_top) begin
      r_next.discharging = 1'b1;
      r_next.phase       = !r_reg.phase;
    end else begin
      r_next.ramp = r_reg.ramp + RW'(1);
    end

    pulse_ok = r_next.res_en && !r_next.discharging &&
               !(r_reg.skip_en && !c.skip_high);
    r_next.low  = pulse_ok && !r_next.phase;
    r_next.high = pulse_ok && r_next.phase &&
                  c.hs_supply_ok;

    // Bus: ack one cycle after the strobe, write at the ack edge
    r_next.ack = i_wb_cyc && i_wb_stb && !r_reg.ack;
    r_next.dat = r_next.ack ? read_word(r_reg, i_wb_adr) : 32'h0000_0000;
    wr = i_wb_cyc && i_wb_stb && i_wb_we && r_reg.ack;
    // A function result cannot be indexed, so the merged word is kept
    if (wr && i_wb_adr == combo_seq_pkg::ADDR_CTRL) begin
      wword          = merge(32'(r_reg.skip_en), i_wb_dat, i_wb_sel);
      r_next.skip_en = wword[0];
    end
    if (wr && i_wb_adr == combo_seq_pkg::ADDR_RAMP) begin
      wword           = merge(32'(r_reg.ramp_top), i_wb_dat, i_wb_sel);
      r_next.ramp_top = wword[RW-1:0];
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_reg          <= '0;
      r_reg.seq      <= combo_seq_pkg::SEQ_IDLE;
      r_reg.ss_dis   <= 1'b1;
      r_reg.skip_en  <= combo_seq_pkg::SKIP_EN_RST;
      r_reg.ramp_top <= combo_seq_pkg::RAMP_TOP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_wb_ack               = r_reg.ack;
  assign o_wb_dat               = r_reg.dat;
  assign o_front_end_enable     = r_reg.fe_run;
  assign o_front_end_good       = r_reg.fe_good;
  assign o_resonant_enable      = r_reg.res_en;
  assign o_power_good_low       = r_reg.pg_low;
  assign o_soft_start_discharge = r_reg.ss_dis;
  assign o_latched_off          = r_reg.latched;
  assign o_low_side_drive       = r_reg.low;
  assign o_high_side_drive      = r_reg.high;

endmodule

`default_nettype wire

// File: combo_seq_properties.sv
/*
  Concurrent checks on the ports of the protection sequencer.
  Assumes one clock, a synchronous active-high reset, and is bound
  to every instance of the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none

module combo_seq_properties #(
  parameter int unsigned START_CYCLES = 20,
  parameter int unsigned REDUNDANT_OVERVOLTAGE_CYCLES  = 8
) (
  // Clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_rst,
  // Observed ports
  input wire combo_seq_pkg::comp_t i_comp,
  input wire logic                 i_wb_cyc,
  input wire logic                 i_wb_stb,
  input wire logic                 o_wb_ack,
  input wire logic [31:0]          o_wb_dat,
  input wire logic                 o_front_end_enable,
  input wire logic                 o_front_end_good,
  input wire logic                 o_resonant_enable,
  input wire logic                 o_power_good_low,
  input wire logic                 o_soft_start_discharge,
  input wire logic                 o_latched_off,
  input wire logic                 o_low_side_drive,
  input wire logic                 o_high_side_drive
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Run lengths of the over-voltage input and of front end good
  logic [31:0] ovp_cnt;
  logic [31:0] good_cnt;
  always_ff @(posedge i_clk) begin
    ovp_cnt  <= (i_rst || !i_comp.redundant_overvoltage) ? '0 : ovp_cnt + 1;
    good_cnt <= (i_rst || !o_front_end_good) ? '0 : good_cnt + 1;
  end

  sequence fe_lost_s;
    $fell(o_front_end_good);
  endsequence

  chk_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack) else $error("bus answer late");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack");
  chk_dead_time: assert property (
    !(o_low_side_drive && o_high_side_drive))
    else $error("both drives on");
  chk_hs_inhibit: assert property (
    (!i_comp.hs_supply_ok)[*2] |-> !o_high_side_drive)
    else $error("high drive without supply");
  chk_latch_stops: assert property (o_latched_off[*3]
    |-> !o_front_end_enable && !o_resonant_enable && !o_low_side_drive)
    else $error("stage running while latched");
  chk_ovp_filter: assert property (
    ovp_cnt > REDUNDANT_OVERVOLTAGE_CYCLES + 3 |-> o_latched_off)
    else $error("filtered over-voltage did not latch");
  chk_pg_delay: assert property ($rose(o_power_good_low)
    |-> good_cnt >= START_CYCLES)
    else $error("power good before start delay");
  chk_pg_release: assert property (
    fe_lost_s |-> ##[0:2] !o_power_good_low)
    else $error("power good held after fault");
  chk_ss_hold: assert property ($fell(o_soft_start_discharge)
    |-> $past(i_comp.ss_below_reset))
    else $error("discharge released early");
  chk_remote_off: assert property (i_comp.remote_above_off[*3]
    |-> !o_front_end_enable && !o_resonant_enable)
    else $error("remote off ignored");
endmodule

bind combo_protection_sequencer combo_seq_properties #(
  .START_CYCLES(START_CYCLES),
  .REDUNDANT_OVERVOLTAGE_CYCLES (REDUNDANT_OVERVOLTAGE_CYCLES)
) u_props (
  .i_clk, .i_rst, .i_comp, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_wb_dat,
  .o_front_end_enable, .o_front_end_good, .o_resonant_enable,
  .o_power_good_low, .o_soft_start_discharge, .o_latched_off,
  .o_low_side_drive, .o_high_side_drive
);

`default_nettype wire

// File: power_stage_model.sv
/*
  Behavioural power stage: bulk and soft-start capacitor levels.
  Assumes enables from the sequencer; levels need 8 ticks to settle.
*/
`timescale 1ns/1ps
`default_nettype none

module power_stage_model (
  // Clock
  input  wire logic i_clk,
  // Stage commands
  input  wire logic i_front_end_enable,
  input  wire logic i_soft_start_discharge,
  // Sensed levels
  output logic      o_bulk_above_good,
  output logic      o_ss_below_reset
);
  logic [3:0] bulk_cnt = 4'h0;
  logic [3:0] ss_cnt   = 4'h0;
  // Bulk sags at once when the boost stops; slow rise exposes early starts
  always_ff @(posedge i_clk) begin
    bulk_cnt <= !i_front_end_enable ? 4'h0 : bulk_cnt[3] ? bulk_cnt
                : bulk_cnt + 4'h1;
    ss_cnt   <= !i_soft_start_discharge ? 4'h0 : ss_cnt[3] ? ss_cnt
                : ss_cnt + 4'h1;
  end
  assign o_bulk_above_good = bulk_cnt[3];
  assign o_ss_below_reset  = ss_cnt[3];
endmodule

`default_nettype wire

// File: combo_protection_sequencer_tb.sv
/*
  Self-checking bench for the protection sequencer.
  Assumes the partner model supplies bulk and soft-start levels.
*/
`timescale 1ns/1ps
`default_nettype none

module combo_protection_sequencer_tb;
  localparam int unsigned START_N = 20;
  localparam int unsigned STOP_N  = 10;
  localparam int unsigned REDUNDANT_OVERVOLTAGE_N  = 8;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  combo_seq_pkg::comp_t drv;
  combo_seq_pkg::comp_t comp;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd_v;
  logic ack, fe_en, fe_good, res_en, pg_low, ss_dis, latched, lo, hi;
  logic bulk_good, ss_low, alt_bad;
  int bad_count = 0;
  int n_checks  = 0;
  int lo_n, hi_n;

  always #2 i_clk = ~i_clk;
  always_comb begin
    comp = drv;
    comp.bulk_above_good = bulk_good;
    comp.ss_below_reset  = ss_low;
  end

  combo_protection_sequencer #(.START_CYCLES(START_N),
    .STOP_CYCLES(STOP_N), .REDUNDANT_OVERVOLTAGE_CYCLES(REDUNDANT_OVERVOLTAGE_N), .BO_OK_CYCLES(4),
    .BO_BAD_CYCLES(4), .ABN_CYCLES(4)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_comp(comp), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
    .o_front_end_enable(fe_en), .o_front_end_good(fe_good),
    .o_resonant_enable(res_en), .o_power_good_low(pg_low),
    .o_soft_start_discharge(ss_dis), .o_latched_off(latched),
    .o_low_side_drive(lo), .o_high_side_drive(hi));

  power_stage_model u_stage (.i_clk(i_clk), .i_front_end_enable(fe_en),
    .i_soft_start_discharge(ss_dis), .o_bulk_above_good(bulk_good),
    .o_ss_below_reset(ss_low));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd_v = rdat;
    if (n >= 50) check(1'b0, 1'b1);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Counts drive pulses; a phase leading the other by two pulses is flagged
  task automatic watch(input int n);
    logic pl, ph;
    pl = 1'b0; ph = 1'b0; lo_n = 0; hi_n = 0; alt_bad = 1'b0;
    repeat (n) begin
      @(posedge i_clk);
      if (lo && !pl) begin lo_n++; alt_bad |= (lo_n > hi_n + 1); end
      if (hi && !ph) begin hi_n++; alt_bad |= (hi_n > lo_n + 1); end
      pl = lo; ph = hi;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    drv = '0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0, 4'hF); check(rd_v, 32'h0);
    wb(1'b0, 8'h04, 32'h0, 4'hF); check(rd_v, 32'h00000100);
    wb(1'b1, 8'h04, 32'hFFFF0010, 4'h1);
    wb(1'b0, 8'h04, 32'h0, 4'hF); check(rd_v & 32'hFFFF, 32'h0110);
    wb(1'b1, 8'h04, 32'h00000010, 4'hF);
    wb(1'b1, 8'h0C, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, 8'h0C, 32'h0, 4'hF); check(rd_v, 32'h0);
    @(posedge i_clk);
    drv.supply_ok <= 1'b1; drv.remote_below_on <= 1'b1;
    drv.bo_above <= 1'b1; drv.fb_above_uv_on <= 1'b1;
    drv.hs_supply_ok <= 1'b1; drv.skip_high <= 1'b1; drv.pg_above <= 1'b1;
    for (int k = 0; k < 200 && fe_good !== 1'b1; k++) @(posedge i_clk);
    check(fe_good, 1'b1);
    repeat (START_N - 2) begin
      @(posedge i_clk);
      check(pg_low, 1'b0);
    end
    for (int k = 0; k < 100 && pg_low !== 1'b1; k++) @(posedge i_clk);
    check({pg_low, res_en}, 2'b11);
    check(ss_dis, 1'b0);
    watch(400); check(lo_n > 3 && hi_n > 3, 1'b1);
    check(alt_bad, 1'b0);
    wb(1'b1, 8'h00, 32'h1, 4'hF);
    drv.skip_high <= 1'b0; tick(3);
    watch(100); check(lo_n + hi_n, 32'h0);
    drv.skip_high <= 1'b1;
    watch(100); check(lo_n > 0, 1'b1);
    drv.hs_supply_ok <= 1'b0; tick(3);
    watch(100); check(hi_n, 32'h0);
    drv.hs_supply_ok <= 1'b1;
    drv.pg_above <= 1'b0; tick(3);
    check({pg_low, res_en}, 2'b01);
    for (int k = 0; k < 30 && res_en !== 1'b0; k++) @(posedge i_clk);
    tick(2);
    check({res_en, lo, hi, ss_dis}, 4'b0001);
    drv.pg_above <= 1'b1;
    // Let the stop-delay discharge end so the fast fault alone sets it
    for (int k = 0; k < 30 && ss_dis !== 1'b0; k++) @(posedge i_clk);
    drv.ff_soft <= 1'b1; tick(3);
    check(ss_dis, 1'b1);
    drv.ff_soft <= 1'b0;
    drv.redundant_overvoltage <= 1'b1; tick(REDUNDANT_OVERVOLTAGE_N - 2);
    drv.redundant_overvoltage <= 1'b0; tick(5);
    check(latched, 1'b0);
    drv.redundant_overvoltage <= 1'b1; tick(REDUNDANT_OVERVOLTAGE_N + 4);
    drv.redundant_overvoltage <= 1'b0; tick(3);
    check({latched, fe_en, res_en}, 3'b100);
    wb(1'b0, 8'h08, 32'h0, 4'hF); check(rd_v[6], 1'b1);
    drv.remote_below_on <= 1'b0; drv.remote_above_off <= 1'b1; tick(3);
    check(fe_en, 1'b0);
    drv.remote_below_on <= 1'b1; drv.remote_above_off <= 1'b0; tick(3);
    check(latched, 1'b0);
    for (int k = 0; k < 50 && fe_en !== 1'b1; k++) @(posedge i_clk);
    check(fe_en, 1'b1);
    drv.ff_latch <= 1'b1; tick(3);
    drv.ff_latch <= 1'b0; tick(2);
    check({latched, fe_en}, 2'b10);
    drv.supply_ok <= 1'b0; tick(3);
    drv.supply_ok <= 1'b1; tick(3);
    check(latched, 1'b0);
    for (int k = 0; k < 50 && fe_en !== 1'b1; k++) @(posedge i_clk);
    drv.fb_below_uv <= 1'b1; drv.fb_above_uv_on <= 1'b0; tick(3);
    check({fe_en, ss_dis}, 2'b01);
    drv.fb_below_uv <= 1'b0; tick(3);
    check(fe_en, 1'b0);
    drv.fb_above_uv_on <= 1'b1;
    for (int k = 0; k < 50 && fe_en !== 1'b1; k++) @(posedge i_clk);
    check(fe_en, 1'b1);
    drv.remote_above_off <= 1'b1; tick(2);
    check(fe_en, 1'b0);
    drv.remote_above_off <= 1'b0;
    for (int k = 0; k < 100 && res_en !== 1'b1; k++) @(posedge i_clk);
    drv.ctrl_at_max <= 1'b1; tick(8);
    check({fe_en, res_en, latched}, 3'b010);
    for (int k = 0; k < 50 && latched !== 1'b1; k++) @(posedge i_clk);
    check({latched, res_en, fe_en}, 3'b100);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    summarize();
  end
endmodule

`default_nettype wire
